/* hdl/xsad_cfg.svh */
`ifndef XSAD_CFG_SVH
`define XSAD_CFG_SVH

// ****************************************
// Register pages and addresses
// ****************************************
`define XSAD_PAGE_BASE     8'h00
`define XSAD_PAGE_EXT      8'h0f
`define XSAD_ADDR_DPL      8'h82
`define XSAD_ADDR_DPH      8'h83
`define XSAD_ADDR_PAGE_SEL 8'ha7
`define XSAD_ADDR_XPAGE    8'haa
`define XSAD_SFR_MSB       7
`define XSAD_BIT_LOW_CODE  3'h0

// Registers decoded on every page
`define XSAD_ALLPAGE_LIST 8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'ha0, 8'ha7, \
	8'ha8, 8'ha9, 8'hd0, 8'he0, 8'he6, 8'he7, 8'hf0, 8'hf6, 8'hf7
// Registers decoded only on the extended page
`define XSAD_PAGEF_LIST 8'h85, 8'h86, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, \
	8'ha4, 8'ha5, 8'ha6, 8'hba, 8'hbd

// ****************************************
// Reset values and sizes
// ****************************************
`define XSAD_RST_BYTE      8'h00
`define XSAD_RST_XPAGE     4'h0
`define XSAD_RST_DATA_POINTER      16'h0000
`define XSAD_RST_ADDR      16'h0000
`define XSAD_XPAGE_W       4
`define XSAD_ON_CHIP_EXTERNAL_RAM_BYTES    4096
`define XSAD_MAX_BYTES     65536
`define XSAD_MIN_BYTES     256
`define XSAD_OUT_RANGE     8'h00

`endif

/* hdl/xsad_pkg.sv */
package xsad_pkg;
	typedef enum logic [1:0] {
		XSAD_ROUTE_NONE,
		XSAD_ROUTE_IRAM_LO,
		XSAD_ROUTE_IRAM_HI,
		XSAD_ROUTE_SFR
	} xsad_route_t;
endpackage

/* hdl/xsad_decode.sv */
`timescale 1ns/1ps
`include "xsad_cfg.svh"
// Notes on behaviour
// (RULE_01) Pointer-form external move uses the whole 16-bit data pointer as address.
// (RULE_02) Index form: high byte from page field, low byte from R0 or R1.
// (RULE_03) Data pointer also reads and writes as high and low byte registers.
// (RULE_04) Page register bits 7:4 read zero; bits 3:0 read/write, reset zero.
// (RULE_05) Page value picks one 256-byte page for index-form accesses.
// (RULE_06) External moves hit on-chip RAM unless writes are redirected to flash.
// (RULE_07) Page register sits on register page 0x0 at 0xAA.
// (RULE_08) Direct accesses to 0x80-0xFF go to special function registers.
// (RULE_09) Registers at addresses ending 0 or 8 allow bit access too.
// (RULE_10) Software avoids unoccupied register addresses.
// (RULE_11) After reset all register accesses decode on page 0x0.
// (RULE_12) Core registers decode on both pages; others on page 0xF only there.
// (RULE_13) Page 0xF maps CRC, drive strength and converter timing registers.
// (RULE_14) Software masks interrupts around page 0xF accesses.
// (RULE_15) Page select at 0xA7, all pages, read/write, resets to zero.
// (RULE_16) Indirect accesses above 0x7F reach upper internal RAM.
// (RULE_17) 4096 bytes of on-chip RAM reachable by both move forms.
// (RULE_18) Addresses beyond the RAM write nothing and read zero.
// (RULE_19) A write is readable by the very next external move read.
module xsad_decode #(
	parameter int ON_CHIP_EXTERNAL_RAM_BYTES = `XSAD_ON_CHIP_EXTERNAL_RAM_BYTES
) (
	input  wire logic                 clk,
	input  wire logic                 nrst,
	input  wire logic                 mem_valid,
	input  wire logic                 mem_direct,
	input  wire logic                 mem_wr,
	input  wire logic                 mem_bit,
	input  wire logic [7:0]           mem_addr,
	input  wire logic [7:0]           mem_wdata,
	input  wire logic                 data_pointer_load,
	input  wire logic [15:0]          data_pointer_load_val,
	input  wire logic                 xmove_valid,
	input  wire logic                 xmove_wr,
	input  wire logic                 xmove_use_data_pointer,
	input  wire logic [7:0]           xmove_index,
	input  wire logic [7:0]           xmove_wdata,
	input  wire logic                 flash_redirect,
	output xsad_pkg::xsad_route_t     mem_route,
	output logic                      sfr_ext_sel,
	output logic                      sfr_ext_pagef,
	output logic                      sfr_local_hit,
	output logic                      sfr_bit_ok,
	output logic                      sfr_bit_refused,
	output logic [7:0]                sfr_rdata,
	output logic [7:0]                register_page_select,
	output logic [15:0]               data_pointer,
	output logic [7:0]                on_chip_external_ram_rdata,
	output logic                      flash_wr_req,
	output logic [15:0]               flash_wr_addr,
	output logic [7:0]                flash_wr_data
);
	import xsad_pkg::*;

	localparam int AW = $clog2(ON_CHIP_EXTERNAL_RAM_BYTES);

	generate
		if (ON_CHIP_EXTERNAL_RAM_BYTES < `XSAD_MIN_BYTES || ON_CHIP_EXTERNAL_RAM_BYTES > `XSAD_MAX_BYTES ||
			(ON_CHIP_EXTERNAL_RAM_BYTES & (ON_CHIP_EXTERNAL_RAM_BYTES - 1)) != 0) begin : g_bad_size
			$error("ON_CHIP_EXTERNAL_RAM_BYTES must be a power of two from 256 to 65536");
		end
	endgenerate

	// ****************************************
	// Register page classification
	// ****************************************
	function automatic logic on_all_pages(input logic [7:0] a);
		case (a)
			`XSAD_ALLPAGE_LIST: on_all_pages = 1'b1;
			default:            on_all_pages = 1'b0;
		endcase
	endfunction

	function automatic logic on_pagef_only(input logic [7:0] a);
		case (a)
			`XSAD_PAGEF_LIST: on_pagef_only = 1'b1;
			default:          on_pagef_only = 1'b0;
		endcase
	endfunction

	logic [7:0]              page_reg;
	logic [7:0]              page_next;
	logic [`XSAD_XPAGE_W-1:0] xpage_reg;
	logic [`XSAD_XPAGE_W-1:0] xpage_next;
	logic [15:0]             data_pointer_reg;
	logic [15:0]             data_pointer_next;
	logic [7:0]              sfr_rdata_reg;
	logic [7:0]              sfr_rdata_next;
	logic [7:0]              on_chip_external_ram_rdata_reg;
	logic                    flash_req_reg;
	logic [15:0]             flash_addr_reg;
	logic [7:0]              flash_data_reg;
	logic [7:0]              on_chip_external_ram_mem [ON_CHIP_EXTERNAL_RAM_BYTES];

	// ****************************************
	// Direct and indirect routing
	// ****************************************
	wire upper_half = mem_addr[`XSAD_SFR_MSB];
	wire sfr_acc    = mem_valid & mem_direct & upper_half; // RULE_08
	wire page_base  = (page_reg == `XSAD_PAGE_BASE); // RULE_11
	wire page_ext   = (page_reg == `XSAD_PAGE_EXT);
	wire all_pg     = on_all_pages(mem_addr);
	wire fonly      = on_pagef_only(mem_addr);
	wire bit_addr   = (mem_addr[2:0] == `XSAD_BIT_LOW_CODE); // RULE_09
	wire byte_wr    = mem_wr & ~mem_bit;

	assign mem_route = !mem_valid ? XSAD_ROUTE_NONE :
		!upper_half ? XSAD_ROUTE_IRAM_LO :
		mem_direct ? XSAD_ROUTE_SFR : XSAD_ROUTE_IRAM_HI; // RULE_08 RULE_16

	wire hit_page = sfr_acc & (mem_addr == `XSAD_ADDR_PAGE_SEL); // RULE_15
	wire hit_dpl  = sfr_acc & (mem_addr == `XSAD_ADDR_DPL); // RULE_03
	wire hit_dph  = sfr_acc & (mem_addr == `XSAD_ADDR_DPH); // RULE_03
	wire hit_xpg  = sfr_acc & page_base & (mem_addr == `XSAD_ADDR_XPAGE); // RULE_07

	assign sfr_local_hit   = hit_page | hit_dpl | hit_dph | hit_xpg;
	assign sfr_bit_ok      = sfr_acc & mem_bit & bit_addr; // RULE_09
	assign sfr_bit_refused = sfr_acc & mem_bit & ~bit_addr; // RULE_09
	// Peripheral strobe follows the active page
	assign sfr_ext_sel   = sfr_acc & ~sfr_local_hit & ~sfr_bit_refused &
		(page_base | all_pg | (page_ext & fonly)); // RULE_11 RULE_12
	assign sfr_ext_pagef = sfr_ext_sel & page_ext & fonly; // RULE_12 RULE_13

	// ****************************************
	// Local registers
	// ****************************************
	assign page_next  = (hit_page & byte_wr) ? mem_wdata : page_reg; // RULE_15
	assign xpage_next = (hit_xpg & byte_wr) ? mem_wdata[`XSAD_XPAGE_W-1:0] : xpage_reg; // RULE_04
	assign data_pointer_next  = data_pointer_load ? data_pointer_load_val :
		(hit_dph & byte_wr) ? {mem_wdata, data_pointer_reg[7:0]} :
		(hit_dpl & byte_wr) ? {data_pointer_reg[15:8], mem_wdata} : data_pointer_reg; // RULE_03

	// Upper bits of the page register read as zero
	assign sfr_rdata_next = (mem_wr || mem_bit) ? sfr_rdata_reg :
		hit_page ? page_reg :
		hit_dph ? data_pointer_reg[15:8] :
		hit_dpl ? data_pointer_reg[7:0] :
		hit_xpg ? {{(8 - `XSAD_XPAGE_W){1'b0}}, xpage_reg} : sfr_rdata_reg; // RULE_04

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			page_reg      <= `XSAD_RST_BYTE;
			xpage_reg     <= `XSAD_RST_XPAGE;
			data_pointer_reg      <= `XSAD_RST_DATA_POINTER;
			sfr_rdata_reg <= `XSAD_RST_BYTE;
		end else begin
			page_reg      <= page_next;
			xpage_reg     <= xpage_next;
			data_pointer_reg      <= data_pointer_next;
			sfr_rdata_reg <= sfr_rdata_next;
		end
	end

	// ****************************************
	// External move address and RAM
	// ****************************************
	wire [15:0] eff_addr = xmove_use_data_pointer ? data_pointer_reg :
		{{(8 - `XSAD_XPAGE_W){1'b0}}, xpage_reg, xmove_index}; // RULE_01 RULE_02 RULE_05
	wire in_range   = ({1'b0, eff_addr} < 17'(ON_CHIP_EXTERNAL_RAM_BYTES)); // RULE_17 RULE_18
	wire to_flash   = xmove_valid & xmove_wr & flash_redirect; // RULE_06
	wire ram_write  = xmove_valid & xmove_wr & ~flash_redirect & in_range; // RULE_18
	wire ram_read   = xmove_valid & ~xmove_wr;

	always_ff @(posedge clk) begin
		if (ram_write) begin
			on_chip_external_ram_mem[eff_addr[AW-1:0]] <= xmove_wdata; // RULE_19
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			on_chip_external_ram_rdata_reg <= `XSAD_RST_BYTE;
			flash_req_reg  <= 1'b0;
			flash_addr_reg <= `XSAD_RST_ADDR;
			flash_data_reg <= `XSAD_RST_BYTE;
		end else begin
			if (ram_read) begin
				on_chip_external_ram_rdata_reg <= in_range ? on_chip_external_ram_mem[eff_addr[AW-1:0]] : `XSAD_OUT_RANGE;
			end
			flash_req_reg <= to_flash; // RULE_06
			if (to_flash) begin
				flash_addr_reg <= eff_addr;
				flash_data_reg <= xmove_wdata;
			end
		end
	end

	assign sfr_rdata            = sfr_rdata_reg;
	assign register_page_select = page_reg;
	assign data_pointer         = data_pointer_reg;
	assign on_chip_external_ram_rdata           = on_chip_external_ram_rdata_reg;
	assign flash_wr_req         = flash_req_reg;
	assign flash_wr_addr        = flash_addr_reg;
	assign flash_wr_data        = flash_data_reg;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_ram_wr;
		ram_write;
	endsequence
	sequence s_rd_same;
		ram_read && in_range && eff_addr == $past(eff_addr);
	endsequence
	sequence s_xpg_wr;
		hit_xpg && mem_wr && !mem_bit;
	endsequence
	sequence s_xpg_rd;
		hit_xpg && !mem_wr && !mem_bit;
	endsequence

	chk_data_pointer_form: assert property ( // RULE_01
		xmove_valid && xmove_use_data_pointer |-> eff_addr == data_pointer)
		else $error("pointer form address differs from data pointer");
	chk_index_form: assert property ( // RULE_02
		xmove_valid && !xmove_use_data_pointer |->
		eff_addr[7:0] == xmove_index && eff_addr[15:8] == {4'h0, xpage_reg})
		else $error("index form address wrong");
	chk_dph_read: assert property ( // RULE_03
		hit_dph && !mem_wr && !mem_bit && !data_pointer_load |=>
		sfr_rdata == $past(data_pointer[15:8]))
		else $error("high pointer byte read wrong");
	chk_xpage_upper: assert property ( // RULE_04 RULE_07
		s_xpg_wr ##1 s_xpg_rd |=>
		sfr_rdata[7:4] == 4'h0 && sfr_rdata[3:0] == $past(mem_wdata[3:0], 2))
		else $error("page register readback wrong");
	chk_sfr_route: assert property ( // RULE_08
		mem_valid && upper_half |->
		mem_route == (mem_direct ? XSAD_ROUTE_SFR : XSAD_ROUTE_IRAM_HI))
		else $error("upper half routed wrong");
	chk_bit_class: assert property ( // RULE_09
		sfr_acc && mem_bit |->
		sfr_bit_ok == (mem_addr[2:0] == 3'h0) && sfr_bit_refused != sfr_bit_ok)
		else $error("bit access class wrong");
	chk_page_hold: assert property ( // RULE_11
		!(hit_page && mem_wr && !mem_bit) |=>
		register_page_select == $past(register_page_select))
		else $error("page changed without write");
	chk_page_write: assert property ( // RULE_15
		hit_page && mem_wr && !mem_bit |=>
		register_page_select == $past(mem_wdata))
		else $error("page select write lost");
	chk_ext_page: assert property ( // RULE_12 RULE_13
		sfr_ext_pagef == (mem_valid && mem_direct && !mem_bit &&
		register_page_select == 8'h0f && (mem_addr inside {`XSAD_PAGEF_LIST})))
		else $error("extended page register selection wrong");
	chk_no_flash: assert property ( // RULE_06
		xmove_valid && xmove_wr && !flash_redirect |=> !flash_wr_req)
		else $error("flash write without redirect");
	chk_out_range: assert property ( // RULE_18
		ram_read && !in_range |=> on_chip_external_ram_rdata == 8'h00)
		else $error("out of range read not zero");
	chk_wr_rd: assert property ( // RULE_19
		s_ram_wr ##1 s_rd_same |=> on_chip_external_ram_rdata == $past(xmove_wdata, 2))
		else $error("write not visible to next read");
endmodule

/* tb/xsad_core_model.sv */
`timescale 1ns/1ps
module xsad_core_model (
	input  wire logic        clk,
	output logic             mem_valid,
	output logic             mem_direct,
	output logic             mem_wr,
	output logic             mem_bit,
	output logic [7:0]       mem_addr,
	output logic [7:0]       mem_wdata,
	output logic             data_pointer_load,
	output logic [15:0]      data_pointer_load_val,
	output logic             xmove_valid,
	output logic             xmove_wr,
	output logic             xmove_use_data_pointer,
	output logic [7:0]       xmove_index,
	output logic [7:0]       xmove_wdata,
	output logic             flash_redirect
);
	initial begin
		{mem_valid, mem_direct, mem_wr, mem_bit, mem_addr, mem_wdata} = '0;
		{data_pointer_load, data_pointer_load_val, xmove_valid, xmove_wr, xmove_use_data_pointer} = '0;
		{xmove_index, xmove_wdata, flash_redirect} = '0;
	end
	// Register access, held until the next call; any address, occupied or not
	task sfr(input logic d, w, b, input logic [7:0] a, wd);
		@(posedge clk);
		xmove_valid <= 1'b0;
		data_pointer_load <= 1'b0;
		mem_valid <= 1'b1;
		{mem_direct, mem_wr, mem_bit, mem_addr, mem_wdata} <= {d, w, b, a, wd};
		#1;
	endtask
	task xm(input logic w, p, f, input logic [7:0] i, wd);
		@(posedge clk);
		mem_valid <= 1'b0;
		data_pointer_load <= 1'b0;
		xmove_valid <= 1'b1;
		{xmove_wr, xmove_use_data_pointer, flash_redirect, xmove_index, xmove_wdata} <= {w, p, f, i, wd};
		#1;
	endtask
	task ld(input logic [15:0] v);
		@(posedge clk);
		mem_valid <= 1'b0;
		xmove_valid <= 1'b0;
		data_pointer_load <= 1'b1;
		data_pointer_load_val <= v;
		#1;
	endtask
	task idle;
		@(posedge clk);
		{mem_valid, xmove_valid, data_pointer_load} <= 3'h0;
		#1;
	endtask
endmodule

/* tb/on_chip_external_ram_sfr_address_decode_tb.sv */
`timescale 1ns/1ps
module on_chip_external_ram_sfr_address_decode_tb;
	import xsad_pkg::*;
	logic clk, nrst, mem_valid, mem_direct, mem_wr, mem_bit, data_pointer_load, xmove_valid;
	logic xmove_wr, xmove_use_data_pointer, flash_redirect, sfr_ext_sel, sfr_ext_pagef;
	logic sfr_local_hit, sfr_bit_ok, sfr_bit_refused, flash_wr_req;
	logic [7:0] mem_addr, mem_wdata, xmove_index, xmove_wdata, sfr_rdata;
	logic [7:0] register_page_select, on_chip_external_ram_rdata, flash_wr_data;
	logic [15:0] data_pointer_load_val, data_pointer, flash_wr_addr;
	xsad_route_t mem_route;
	int mismatches, check_count, cyc;
	xsad_core_model m (.clk(clk), .mem_valid(mem_valid), .mem_direct(mem_direct),
		.mem_wr(mem_wr), .mem_bit(mem_bit), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.data_pointer_load(data_pointer_load), .data_pointer_load_val(data_pointer_load_val), .xmove_valid(xmove_valid),
		.xmove_wr(xmove_wr), .xmove_use_data_pointer(xmove_use_data_pointer), .xmove_index(xmove_index),
		.xmove_wdata(xmove_wdata), .flash_redirect(flash_redirect));
	xsad_decode u_dut (.clk(clk), .nrst(nrst), .mem_valid(mem_valid),
		.mem_direct(mem_direct), .mem_wr(mem_wr), .mem_bit(mem_bit), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .data_pointer_load(data_pointer_load), .data_pointer_load_val(data_pointer_load_val),
		.xmove_valid(xmove_valid), .xmove_wr(xmove_wr), .xmove_use_data_pointer(xmove_use_data_pointer),
		.xmove_index(xmove_index), .xmove_wdata(xmove_wdata),
		.flash_redirect(flash_redirect), .mem_route(mem_route), .sfr_ext_sel(sfr_ext_sel),
		.sfr_ext_pagef(sfr_ext_pagef), .sfr_local_hit(sfr_local_hit),
		.sfr_bit_ok(sfr_bit_ok), .sfr_bit_refused(sfr_bit_refused), .sfr_rdata(sfr_rdata),
		.register_page_select(register_page_select), .data_pointer(data_pointer),
		.on_chip_external_ram_rdata(on_chip_external_ram_rdata), .flash_wr_req(flash_wr_req),
		.flash_wr_addr(flash_wr_addr), .flash_wr_data(flash_wr_data));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task chk(input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 1000) begin
			mismatches++;
			wrap_up;
		end
	end
	task t_reset;
		chk(register_page_select, 16'h0000);
		chk(data_pointer, 16'h0000);
		m.sfr(1, 0, 0, 8'haa, 8'h00);
		chk(sfr_local_hit, 1'b1);
		m.idle;
		chk(sfr_rdata, 16'h0000);
	endtask
	task t_xpage;
		m.sfr(1, 1, 0, 8'haa, 8'hff);
		m.sfr(1, 0, 0, 8'haa, 8'h00);
		m.xm(1, 0, 0, 8'h34, 8'h5a);
		chk(sfr_rdata, 16'h000f);
		m.ld(16'h0f34);
		m.xm(0, 1, 0, 8'h00, 8'h00);
		m.idle;
		chk(on_chip_external_ram_rdata, 16'h005a);
		m.xm(1, 1, 0, 8'h00, 8'ha5);
		m.xm(0, 1, 0, 8'h00, 8'h00);
		m.idle;
		chk(on_chip_external_ram_rdata, 16'h00a5);
	endtask
	task t_data_pointer;
		m.sfr(1, 1, 0, 8'h83, 8'h12);
		m.sfr(1, 1, 0, 8'h82, 8'h34);
		m.idle;
		chk(data_pointer, 16'h1234);
		m.xm(1, 1, 0, 8'h00, 8'h77);
		m.xm(0, 1, 0, 8'h00, 8'h00);
		m.idle;
		chk(on_chip_external_ram_rdata, 16'h0000);
	endtask
	task t_route;
		m.sfr(1, 0, 0, 8'h90, 8'h00);
		chk(mem_route, XSAD_ROUTE_SFR);
		m.sfr(0, 0, 0, 8'h90, 8'h00);
		chk(mem_route, XSAD_ROUTE_IRAM_HI);
		m.sfr(0, 0, 0, 8'h10, 8'h00);
		chk(mem_route, XSAD_ROUTE_IRAM_LO);
		m.sfr(1, 0, 1, 8'h88, 8'h00);
		chk(sfr_bit_ok, 1'b1);
		m.sfr(1, 0, 1, 8'h89, 8'h00);
		chk({sfr_bit_refused, sfr_ext_sel}, 2'h2);
		m.sfr(1, 1, 1, 8'h83, 8'h99);
		chk(sfr_bit_refused, 1'b1);
		m.idle;
		chk(data_pointer, 16'h1234);
	endtask
	task t_pagef;
		logic [7:0] only_f [14];
		only_f = '{8'h85, 8'h86, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'ha4,
			8'ha5, 8'ha6, 8'hba, 8'hbd};
		m.sfr(1, 1, 0, 8'ha7, 8'h0f);
		foreach (only_f[i]) begin
			m.sfr(1, 0, 0, only_f[i], 8'h00);
			chk({sfr_ext_sel, sfr_ext_pagef}, 2'h3);
		end
		chk(register_page_select, 16'h000f);
		m.sfr(1, 0, 0, 8'he0, 8'h00);
		chk({sfr_ext_sel, sfr_ext_pagef}, 2'h2);
		m.sfr(1, 1, 0, 8'haa, 8'h03);
		m.sfr(1, 1, 0, 8'ha7, 8'h00);
		chk(sfr_local_hit, 1'b1);
		m.sfr(1, 0, 0, 8'haa, 8'h00);
		m.sfr(1, 0, 0, 8'h91, 8'h00);
		chk(sfr_rdata, 16'h000f);
		chk(sfr_ext_pagef, 1'b0);
	endtask
	task t_flash;
		m.xm(1, 0, 1, 8'h34, 8'hc3);
		m.idle;
		chk(flash_wr_addr, 16'h0f34);
		chk({flash_wr_req, flash_wr_data}, 16'h01c3);
		m.xm(0, 0, 0, 8'h34, 8'h00);
		m.idle;
		chk(on_chip_external_ram_rdata, 16'h00a5);
	endtask
	initial begin
		nrst = 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		#1;
		t_reset;
		t_xpage;
		t_data_pointer;
		t_route;
		t_pagef;
		t_flash;
		wrap_up;
	end
endmodule
